//--- async_serial_baud_core.sv
// asynchronous serial core with baud generator and byte register map
// Overview of operation
// - bit rate is clock over sixteen times divisor
// - divisor is thirteen bits, values one to 8191
// - generator idle until first transmitter or receiver enable
// - divisor zero holds the generator disabled
// - upper divisor byte waits for lower byte write
// - halt_in_wait clear keeps running during wait
// - halt_in_wait set stops clocks, enables untouched
// - frames freeze in wait with halt_in_wait set, resume afterwards
// - reset out of wait or stop aborts everything
// - stop mode gates clock, keeps registers, resumes
// - reserved locations ignore writes, read zero
// - eight byte registers at word indices zero to seven
// - eight or nine bits, ninth bits in data-high
// - eight status flags raised by the core
// - noise detected from sixteenth-bit samples
// - full-duplex non-return-to-zero, transmit out, receive in
// - transmitter and receiver enabled independently
// - receiver wakes on idle line or address mark
// - frame is start, eight or nine data, stop
// - parity in top data bit, even or odd
// - loop feeds receiver internally or from transmit pin
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ps
module async_serial_baud_core
   import uart_pkg::*;
(
   // clock and reset
   input wire logic I_CLK,
   input wire logic I_RSTN,
   // avalon-mm slave, byte address
   input wire logic [4:0] I_AVS_ADDRESS,
   input wire logic I_AVS_READ,
   input wire logic I_AVS_WRITE,
   input wire logic [31:0] I_AVS_WRITEDATA,
   input wire logic [3:0] I_AVS_BYTEENABLE,
   output logic [31:0] O_AVS_READDATA,
   output logic O_AVS_WAITREQUEST,
   // processor power modes
   input wire logic I_WAIT_MODE,
   input wire logic I_STOP_MODE,
   // serial pins
   input wire logic I_RXD,
   input wire logic I_TXD_PIN,
   output logic O_TXD,
   output logic O_TXD_OE
);

   // register select on the word index
   function automatic logic hit(input logic [4:0] a, input logic [2:0] idx);
      return a[4:2] == idx;
   endfunction : hit

   logic ack_r; // second cycle of an access
   logic [31:0] readdata_r; // captured read value
   logic req; // any request present
   logic rd; // read completes this edge
   logic wr; // write completes this edge
   logic [7:0] wd; // low write byte
   logic [7:0] rd_mux; // selected read byte
   logic [12:0] div_r; // active divisor
   logic [4:0] bdh_tmp_r; // pending upper divisor bits
   ctl1_s ctl1_r; // control one
   ctl2_s ctl2_r; // control two
   stat1_s st_r; // status one
   logic brk13_r; // stored status-two bit
   logic txdir_r; // single-wire drive direction
   logic sr1_seen_r; // status read armed a clear
   logic [7:0] tx_hold_r; // transmit holding byte
   logic t8_r; // ninth transmit bit
   logic [7:0] rx_data_r; // received low byte
   logic r8_r; // ninth received bit
   logic started_r; // generator released after reset
   logic [12:0] div_cnt_r; // divisor counter
   logic run_en; // clocks not halted by power mode
   logic gen_on; // generator running
   logic tick16; // sixteen-times bit rate pulse
   logic [3:0] tx_sub_r; // transmit sixteenth counter
   logic bit_tick; // transmit bit boundary
   tx_state_e tx_state_r; // transmitter state
   logic [10:0] tx_shift_r; // frame shifter, lsb first
   logic [3:0] tx_cnt_r; // bits left in frame
   logic tx_load; // holding byte moves to shifter
   logic [8:0] tx_word; // character with parity applied
   logic txd_r; // registered line level
   logic single_wire; // receiver listens on transmit pin
   logic [2:0] sync_r; // pin synchroniser chain
   logic rx_filt_r; // agreed pin level
   logic rx_in; // receiver input after loop select
   rx_state_e rx_state_r; // receiver state
   logic [3:0] rx_sub_r; // receive sixteenth counter
   logic [2:0] vote_r; // three mid-bit samples
   logic [3:0] rx_cnt_r; // data bits received
   logic [8:0] rx_shift_r; // receive shifter
   logic maj; // majority of the samples
   logic noisy; // samples disagree
   logic rx_done_r; // frame finished pulse
   rx_result_s rx_res_r; // finished frame
   logic [3:0] nbits; // data bits per frame
   logic [7:0] idle_cnt_r; // sixteenths of high line
   logic [7:0] idle_len; // sixteenths in a full frame
   logic idle_hit; // idle character seen
   logic idle_armed_r; // idle flag allowed after traffic
   logic rx_msb; // address mark bit of frame
   logic wake_hit; // sleeping receiver woken
   logic accept; // frame goes to the flags
   logic rx_clr; // receive flag clear sequence
   logic full_eff; // holding still full this cycle
   logic load_rx; // frame loads the data registers

   // one wait state per access keeps the read mux off the bus path
   assign req = I_AVS_READ | I_AVS_WRITE;
   assign O_AVS_WAITREQUEST = req & ~ack_r;
   assign rd = I_AVS_READ & ack_r;
   assign wr = I_AVS_WRITE & ack_r & I_AVS_BYTEENABLE[0];
   assign wd = I_AVS_WRITEDATA[7:0];
   assign O_AVS_READDATA = readdata_r;

   // access phase tracker
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= req & ~ack_r;
      end
   end

   // read byte selection, upper bits and reserved bits zero
   always_comb begin
      rd_mux = 8'h00;
      unique case (I_AVS_ADDRESS[4:2])
         IDX_BDH: rd_mux = {3'h0, div_r[12:8]};
         IDX_BDL: rd_mux = div_r[7:0];
         IDX_CR1: rd_mux = ctl1_r;
         IDX_CR2: rd_mux = ctl2_r;
         IDX_SR1: rd_mux = st_r;
         IDX_SR2: rd_mux = {5'h00, brk13_r, txdir_r, rx_state_r != RX_IDLE};
         IDX_DRH: rd_mux = {r8_r, t8_r, 6'h00};
         IDX_DRL: rd_mux = rx_data_r;
      endcase
   end

   // read data captured in the wait cycle, held to the answer edge
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         readdata_r <= 32'h0000_0000;
      end else if (I_AVS_READ && !ack_r) begin
         readdata_r <= {24'h00_0000, rd_mux};
      end
   end

   // divisor pair, upper byte parked until the lower byte lands
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         div_r <= DIV_RST;
         bdh_tmp_r <= DIV_RST[12:8];
      end else if (wr && hit(I_AVS_ADDRESS, IDX_BDH)) begin
         bdh_tmp_r <= wd[4:0];
      end else if (wr && hit(I_AVS_ADDRESS, IDX_BDL)) begin
         div_r <= {bdh_tmp_r, wd};
      end
   end

   // control registers; hardware wake clears sleep, a write wins
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         ctl1_r <= CR1_RST;
         ctl2_r <= CR2_RST;
         brk13_r <= 1'b0;
         txdir_r <= 1'b0;
         t8_r <= 1'b0;
      end else begin
         if (wake_hit) begin
            ctl2_r.rx_sleep <= 1'b0;
         end
         if (wr && hit(I_AVS_ADDRESS, IDX_CR1)) begin
            ctl1_r <= wd;
         end
         if (wr && hit(I_AVS_ADDRESS, IDX_CR2)) begin
            ctl2_r <= wd;
         end
         if (wr && hit(I_AVS_ADDRESS, IDX_SR2)) begin
            brk13_r <= wd[2];
            txdir_r <= wd[1];
         end
         if (wr && hit(I_AVS_ADDRESS, IDX_DRH)) begin
            t8_r <= wd[6];
         end
      end
   end

   // baud generator: halted by power mode, divisor zero, or before enable
   assign run_en = ~I_STOP_MODE & ~(I_WAIT_MODE & ctl1_r.halt_in_wait);
   assign gen_on = started_r & (div_r != 13'h0000) & run_en;
   assign tick16 = gen_on & (div_cnt_r >= div_r - 13'h0001);

   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         started_r <= 1'b0;
         div_cnt_r <= 13'h0000;
      end else begin
         if (ctl2_r.transmitter_enable || ctl2_r.receiver_enable) begin
            started_r <= 1'b1;
         end
         if (div_r == 13'h0000) begin
            div_cnt_r <= 13'h0000;
         end else if (gen_on) begin
            div_cnt_r <= tick16 ? 13'h0000 : div_cnt_r + 13'h0001;
         end
      end
   end

   // transmit bit timing, a stall simply withholds the ticks
   assign bit_tick = tick16 & (tx_sub_r == OVS_LAST);
   assign nbits = ctl1_r.nine_bit_mode ? DATA_BITS_9 : DATA_BITS_8;
   // ninth bit only joins the character in nine-bit mode
   assign tx_word = with_parity({ctl1_r.nine_bit_mode & t8_r, tx_hold_r}, ctl1_r);
   assign tx_load = (tx_state_r == TX_IDLE) & ctl2_r.transmitter_enable
                    & ~st_r.tx_holding_empty & bit_tick;

   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         tx_sub_r <= 4'h0;
      end else if (tick16) begin
         tx_sub_r <= tx_sub_r + 4'h1;
      end
   end

   // transmitter: start, data lsb first with parity, stop
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         tx_state_r <= TX_IDLE;
         tx_shift_r <= 11'h7FF;
         tx_cnt_r <= 4'h0;
      end else if (!ctl2_r.transmitter_enable) begin
         tx_state_r <= TX_IDLE;
         tx_shift_r <= 11'h7FF;
      end else if (bit_tick) begin
         unique case (tx_state_r)
            TX_IDLE: begin
               if (tx_load) begin
                  // parity replaces the top data bit when enabled
                  if (ctl1_r.nine_bit_mode) begin
                     tx_shift_r <= {1'b1, tx_word, 1'b0};
                  end else begin
                     tx_shift_r <= {2'b11, tx_word[7:0], 1'b0};
                  end
                  tx_cnt_r <= nbits + FRAME_EXTRA;
                  tx_state_r <= TX_SHIFT;
               end
            end
            TX_SHIFT: begin
               tx_shift_r <= {1'b1, tx_shift_r[10:1]};
               tx_cnt_r <= tx_cnt_r - 4'h1;
               if (tx_cnt_r == 4'h1) begin
                  tx_state_r <= TX_IDLE;
               end
            end
         endcase
      end
   end

   // line level: idle mark, break sends space when idle
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         txd_r <= 1'b1;
      end else if (!ctl2_r.transmitter_enable) begin
         txd_r <= 1'b1;
      end else begin
         txd_r <= (tx_state_r == TX_SHIFT) ? tx_shift_r[0] : ~ctl2_r.send_break;
      end
   end

   // in single-wire mode the pin is driven only when the direction bit says so
   assign single_wire = ctl1_r.loop_select & ctl1_r.receiver_source;
   assign O_TXD = txd_r;
   assign O_TXD_OE = ctl2_r.transmitter_enable & (~single_wire | txdir_r);

   // pin synchroniser; a change counts once stages two and three agree
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         sync_r <= 3'h7;
         rx_filt_r <= 1'b1;
      end else begin
         sync_r <= {sync_r[1:0], single_wire ? I_TXD_PIN : I_RXD};
         if (sync_r[1] == sync_r[2]) begin
            rx_filt_r <= sync_r[2];
         end
      end
   end

   // internal loop takes the transmitter straight, skipping the pins
   assign rx_in = (ctl1_r.loop_select & ~ctl1_r.receiver_source) ? txd_r : rx_filt_r;
   assign maj = (vote_r[0] & vote_r[1]) | (vote_r[0] & vote_r[2]) | (vote_r[1] & vote_r[2]);
   assign noisy = ~(&vote_r) & (|vote_r);

   // receiver: three votes at sixteenths seven to nine of every bit
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         rx_state_r <= RX_IDLE;
         rx_sub_r <= 4'h0;
         vote_r <= 3'h7;
         rx_cnt_r <= 4'h0;
         rx_shift_r <= 9'h000;
         rx_done_r <= 1'b0;
         rx_res_r <= '0;
      end else begin
         rx_done_r <= 1'b0;
         if (!ctl2_r.receiver_enable) begin
            rx_state_r <= RX_IDLE;
         end else if (tick16) begin
            rx_sub_r <= rx_sub_r + 4'h1;
            if (rx_sub_r >= SMP_FIRST && rx_sub_r <= SMP_LAST) begin
               vote_r <= {vote_r[1:0], rx_in};
            end
            unique case (rx_state_r)
               RX_IDLE: begin
                  if (!rx_in) begin
                     rx_state_r <= RX_START;
                     rx_sub_r <= 4'h1;
                  end
               end
               RX_START: begin
                  if (rx_sub_r == OVS_LAST) begin
                     // a start that votes high was a glitch
                     rx_state_r <= maj ? RX_IDLE : RX_DATA;
                     rx_cnt_r <= 4'h0;
                     rx_res_r.noise <= noisy;
                  end
               end
               RX_DATA: begin
                  if (rx_sub_r == OVS_LAST) begin
                     rx_res_r.noise <= rx_res_r.noise | noisy;
                     if (rx_cnt_r != nbits) begin
                        rx_shift_r <= {maj, rx_shift_r[8:1]};
                        rx_cnt_r <= rx_cnt_r + 4'h1;
                     end else begin
                        rx_res_r.word <= ctl1_r.nine_bit_mode ? rx_shift_r
                                         : {1'b0, rx_shift_r[8:1]};
                        rx_res_r.framing <= ~maj;
                        rx_done_r <= 1'b1;
                        rx_state_r <= RX_IDLE;
                     end
                  end
               end
            endcase
         end
      end
   end

   // idle detection: a full frame of high sixteenths
   assign idle_len = {nbits + FRAME_EXTRA, 4'h0};
   assign idle_hit = tick16 & rx_in & (idle_cnt_r == idle_len - 8'h01);

   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         idle_cnt_r <= 8'h00;
      end else if (!ctl2_r.receiver_enable || (rx_done_r && ctl1_r.idle_after_stop)) begin
         idle_cnt_r <= 8'h00;
      end else if (tick16) begin
         if (!rx_in) begin
            idle_cnt_r <= 8'h00;
         end else if (idle_cnt_r != idle_len) begin
            idle_cnt_r <= idle_cnt_r + 8'h01;
         end
      end
   end

   // wake-up and acceptance of a finished frame
   assign rx_msb = ctl1_r.nine_bit_mode ? rx_res_r.word[8] : rx_res_r.word[7];
   assign wake_hit = ctl2_r.rx_sleep & (ctl1_r.wake_on_address ? (rx_done_r & rx_msb)
                                                                : idle_hit);
   assign accept = rx_done_r & (~ctl2_r.rx_sleep | wake_hit);
   assign rx_clr = rd & hit(I_AVS_ADDRESS, IDX_DRL) & sr1_seen_r;
   assign full_eff = st_r.rx_holding_full & ~rx_clr;
   assign load_rx = accept & ~full_eff;

   // receive data registers
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         rx_data_r <= 8'h00;
         r8_r <= 1'b0;
      end else if (load_rx) begin
         rx_data_r <= rx_res_r.word[7:0];
         r8_r <= rx_res_r.word[8];
      end
   end

   // transmit holding byte, kept apart from the receive byte
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         tx_hold_r <= 8'h00;
      end else if (wr && hit(I_AVS_ADDRESS, IDX_DRL)) begin
         tx_hold_r <= wd;
      end
   end

   // clear sequence arm: status read, then data access
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         sr1_seen_r <= 1'b0;
      end else if (rd && hit(I_AVS_ADDRESS, IDX_SR1)) begin
         sr1_seen_r <= 1'b1;
      end else if ((rd || wr) && hit(I_AVS_ADDRESS, IDX_DRL)) begin
         sr1_seen_r <= 1'b0;
      end
   end

   // status flags: clears first, sets after so a same-cycle event wins
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         st_r <= SR1_RST;
         idle_armed_r <= 1'b0;
      end else begin
         if (wr && hit(I_AVS_ADDRESS, IDX_DRL) && sr1_seen_r) begin
            st_r.tx_holding_empty <= 1'b0;
            st_r.tx_complete <= 1'b0;
         end
         if (rx_clr) begin
            st_r.rx_holding_full <= 1'b0;
            st_r.idle_line <= 1'b0;
            st_r.overrun <= 1'b0;
            st_r.noise_flag <= 1'b0;
            st_r.framing_error <= 1'b0;
            st_r.parity_error <= 1'b0;
         end
         if (tx_load) begin
            st_r.tx_holding_empty <= 1'b1;
         end
         if (tx_state_r == TX_IDLE && st_r.tx_holding_empty && !tx_load) begin
            st_r.tx_complete <= 1'b1;
         end
         if (rx_done_r) begin
            idle_armed_r <= 1'b1;
         end else if (idle_hit) begin
            idle_armed_r <= 1'b0;
         end
         if (idle_hit && idle_armed_r && !ctl2_r.rx_sleep) begin
            st_r.idle_line <= 1'b1;
         end
         if (accept && full_eff) begin
            st_r.overrun <= 1'b1;
         end
         if (load_rx) begin
            st_r.rx_holding_full <= 1'b1;
            st_r.noise_flag <= rx_res_r.noise;
            st_r.framing_error <= rx_res_r.framing;
            st_r.parity_error <= ctl1_r.parity_enable
                                 & (with_parity(rx_res_r.word, ctl1_r) != rx_res_r.word);
         end
      end
   end

endmodule : async_serial_baud_core

//--- uart_pkg.sv
// shared constants, types and helpers for the asynchronous serial core
package uart_pkg;

   // register indices; byte address on the bus is four times the index
   localparam logic [2:0] IDX_BDH = 3'h0;
   localparam logic [2:0] IDX_BDL = 3'h1;
   localparam logic [2:0] IDX_CR1 = 3'h2;
   localparam logic [2:0] IDX_CR2 = 3'h3;
   localparam logic [2:0] IDX_SR1 = 3'h4;
   localparam logic [2:0] IDX_SR2 = 3'h5;
   localparam logic [2:0] IDX_DRH = 3'h6;
   localparam logic [2:0] IDX_DRL = 3'h7;

   // reset values
   localparam logic [12:0] DIV_RST = 13'h0000;
   localparam logic [7:0] CR1_RST = 8'h00;
   localparam logic [7:0] CR2_RST = 8'h00;
   localparam logic [7:0] SR1_RST = 8'hC0;

   // oversampling and frame timing counts
   localparam logic [3:0] OVS_LAST = 4'hF;
   localparam logic [3:0] SMP_FIRST = 4'h7;
   localparam logic [3:0] SMP_LAST = 4'h9;
   localparam logic [3:0] DATA_BITS_8 = 4'h8;
   localparam logic [3:0] DATA_BITS_9 = 4'h9;
   localparam logic [3:0] FRAME_EXTRA = 4'h2;

   // control one, msb first
   typedef struct packed {
      logic loop_select;
      logic halt_in_wait;
      logic receiver_source;
      logic nine_bit_mode;
      logic wake_on_address;
      logic idle_after_stop;
      logic parity_enable;
      logic parity_type;
   } ctl1_s;

   // control two, msb first
   typedef struct packed {
      logic tx_empty_ie;
      logic tx_done_ie;
      logic rx_full_ie;
      logic idle_ie;
      logic transmitter_enable;
      logic receiver_enable;
      logic rx_sleep;
      logic send_break;
   } ctl2_s;

   // status one, msb first
   typedef struct packed {
      logic tx_holding_empty;
      logic tx_complete;
      logic rx_holding_full;
      logic idle_line;
      logic overrun;
      logic noise_flag;
      logic framing_error;
      logic parity_error;
   } stat1_s;

   // one finished receive frame
   typedef struct packed {
      logic [8:0] word;
      logic noise;
      logic framing;
   } rx_result_s;

   typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_SHIFT = 2'b01} tx_state_e;
   typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b11} rx_state_e;

   // insert parity into the most significant data position when enabled
   function automatic logic [8:0] with_parity(input logic [8:0] d, input ctl1_s c);
      logic [8:0] r;
      r = d;
      if (c.parity_enable) begin
         if (c.nine_bit_mode) begin
            r[8] = (^d[7:0]) ^ c.parity_type;
         end else begin
            r[7] = (^d[6:0]) ^ c.parity_type;
         end
      end
      return r;
   endfunction : with_parity

endpackage : uart_pkg

//--- async_serial_baud_core_assertions.sv
// bound checker for the serial core bus and pin behaviour
`timescale 1ns/1ps
module async_serial_baud_core_chk (
   // clock and reset
   input wire logic I_CLK,
   input wire logic I_RSTN,
   // bus and power inputs
   input wire logic [4:0] I_AVS_ADDRESS,
   input wire logic I_AVS_READ,
   input wire logic I_AVS_WRITE,
   input wire logic I_STOP_MODE,
   // watched outputs
   input wire logic [31:0] O_AVS_READDATA,
   input wire logic O_AVS_WAITREQUEST,
   input wire logic O_TXD,
   input wire logic O_TXD_OE
);
   default clocking @(posedge I_CLK); endclocking
   default disable iff (!I_RSTN);
   logic rq; // any bus request
   assign rq = I_AVS_READ | I_AVS_WRITE;
   // a read finishing at a given register
   sequence rd_done(logic [2:0] idx);
      I_AVS_READ && !O_AVS_WAITREQUEST && I_AVS_ADDRESS[4:2] == idx;
   endsequence
   // shortest low run: a bit lasts at least sixteen clocks, eight is a safe floor
   sequence low_bit;
      !O_TXD [*8];
   endsequence
   wait_first_a: assert property ($rose(rq) |-> O_AVS_WAITREQUEST)
      else $error("request lacked a wait cycle");
   ack_next_a: assert property (rq && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST)
      else $error("answer did not come next cycle");
   rd_upper_a: assert property (O_AVS_READDATA[31:8] == 24'h000000)
      else $error("upper read bits not zero");
   bdh_zero_a: assert property (rd_done(3'h0) |-> O_AVS_READDATA[7:5] == 3'h0)
      else $error("divisor high reserved bits set");
   sr2_zero_a: assert property (rd_done(3'h5) |-> O_AVS_READDATA[7:3] == 5'h00)
      else $error("status two reserved bits set");
   drh_zero_a: assert property (rd_done(3'h6) |-> O_AVS_READDATA[5:0] == 6'h00)
      else $error("data high reserved bits set");
   bit_len_a: assert property ($fell(O_TXD) |-> low_bit)
      else $error("low bit shorter than a bit time");
   stop_hold_a: assert property (I_STOP_MODE && $past(I_STOP_MODE) |-> $stable(O_TXD))
      else $error("output moved in stop mode");
   rst_idle_a: assert property ($rose(I_RSTN) |-> O_TXD && !O_TXD_OE)
      else $error("pin not idle after reset");
endmodule : async_serial_baud_core_chk
bind async_serial_baud_core async_serial_baud_core_chk u_chk (.I_CLK, .I_RSTN,
   .I_AVS_ADDRESS, .I_AVS_READ, .I_AVS_WRITE, .I_STOP_MODE, .O_AVS_READDATA,
   .O_AVS_WAITREQUEST, .O_TXD, .O_TXD_OE);

//--- serial_peer.sv
// serial peer model: decodes frames from the core and sends frames to it
`timescale 1ns/1ps
module serial_peer #(parameter int BIT = 16) (
   // clock and line in
   input wire logic i_clk,
   input wire logic i_txd,
   // line out and decoded byte
   output logic o_rxd,
   output logic [7:0] o_got,
   output logic o_got_stb
);
   initial begin
      o_rxd = 1'b1; // mark level while idle
      o_got = 8'h00;
      o_got_stb = 1'b0;
   end
   // decode: sample mid-bit after the start edge, lsb first, stop must be mark
   always begin
      @(negedge i_txd);
      repeat (BIT / 2) @(posedge i_clk);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT) @(posedge i_clk);
         o_got[i] <= i_txd;
      end
      repeat (BIT) @(posedge i_clk);
      o_got_stb <= i_txd;
      @(posedge i_clk);
      o_got_stb <= 1'b0;
   end
   // send one frame: start, eight data lsb first, stop
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge i_clk);
         o_rxd <= f[i];
         repeat (BIT - 1) @(posedge i_clk);
      end
   endtask : send
endmodule : serial_peer

//--- async_serial_baud_core_tb_top.sv
// self-checking bench for the serial core with a serial peer on its pins
`timescale 1ns/1ps
module async_serial_baud_core_tb_top import uart_pkg::*;;
   logic clk, rst_n, rd, wr, wt, stp; // driven inputs
   logic [4:0] adr;
   logic [31:0] wd;
   logic [3:0] be;
   logic [31:0] rdat;
   logic wrq, txd, oe, rxd, got_stb, pin;
   logic [7:0] got, seed, q, b;
   int fails, tests_run;
   assign pin = oe ? txd : 1'b1; // pulled-up transmit pin level
   async_serial_baud_core u_dut (.I_CLK(clk), .I_RSTN(rst_n), .I_AVS_ADDRESS(adr),
      .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wd), .I_AVS_BYTEENABLE(be),
      .O_AVS_READDATA(rdat), .O_AVS_WAITREQUEST(wrq), .I_WAIT_MODE(wt),
      .I_STOP_MODE(stp), .I_RXD(rxd), .I_TXD_PIN(pin), .O_TXD(txd), .O_TXD_OE(oe));
   serial_peer #(.BIT(16)) u_peer (.i_clk(clk), .i_txd(txd), .o_rxd(rxd),
      .o_got(got), .o_got_stb(got_stb));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr
   // expected byte on the wire: m 0 no parity, 1 even, 2 odd in bit 7
   function automatic logic [7:0] tx_exp(input logic [7:0] d, input int m);
      logic [7:0] r;
      r = d;
      if (m != 0) r[7] = (^d[6:0]) ^ (m == 2);
      return r;
   endfunction : tx_exp
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      tests_run++;
      if (s !== e) begin
         fails++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   // one bus access; waitrequest and read data are the values sampled at the rising edge
   task automatic bus(input logic w, input logic [2:0] idx, input logic [7:0] d,
      output logic [7:0] r);
      int n;
      n = 0;
      @(posedge clk);
      adr <= {idx, 2'b00};
      rd <= !w;
      wr <= w;
      wd <= {24'h000000, d};
      do begin
         @(posedge clk);
         n++;
      end while (wrq !== 1'b0 && n < 50);
      if (n >= 50) fails++;
      r = rdat[7:0];
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : bus
   task automatic wrt(input logic [2:0] idx, input logic [7:0] d);
      logic [7:0] r;
      bus(1'b1, idx, d, r);
   endtask : wrt
   task automatic rdc(input string n, input logic [2:0] idx, input logic [7:0] e);
      bus(1'b0, idx, 8'h00, q);
      chk(n, q, e);
   endtask : rdc
   // wait for the peer to decode a frame, bounded
   task automatic wait_got;
      int n;
      n = 0;
      while (got_stb !== 1'b1 && n < 2000) begin
         @(posedge clk);
         n++;
      end
      if (n >= 2000) fails++;
   endtask : wait_got
   task automatic close_out;
      $display("checks %0d errors %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : close_out
   initial begin
      repeat (60000) @(posedge clk);
      fails++;
      close_out();
   end
   initial begin
      rst_n = 1'b0; rd = 1'b0; wr = 1'b0; wt = 1'b0; stp = 1'b0;
      adr = 5'h00; wd = 32'h0; be = 4'hF; fails = 0; tests_run = 0; seed = 8'h2A;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 8; i++) rdc("reset", i[2:0], (i == 4) ? 8'hC0 : 8'h00);
      wrt(IDX_SR1, 8'hFF);
      rdc("sr1_ro", IDX_SR1, 8'hC0);
      wrt(IDX_BDH, 8'hF5);
      rdc("bdh_park", IDX_BDH, 8'h00);
      wrt(IDX_BDL, 8'h01); // low byte before readback
      rdc("bdh", IDX_BDH, 8'h15);
      rdc("bdl", IDX_BDL, 8'h01);
      wrt(IDX_BDH, 8'h00);
      wrt(IDX_BDL, 8'h00);
      wrt(IDX_CR2, 8'h08);
      bus(1'b0, IDX_SR1, 8'h00, q);
      b = 8'h5A;
      wrt(IDX_DRL, b);
      repeat (40) @(posedge clk);
      chk("txd_div0", {7'h00, txd}, 8'h01);
      wrt(IDX_BDL, 8'h01);
      wait_got();
      chk("tx_first", got, b);
      for (int m = 0; m < 3; m++) begin
         seed = lfsr(seed);
         wrt(IDX_CR1, (m == 0) ? 8'h00 : ((m == 2) ? 8'h03 : 8'h02));
         bus(1'b0, IDX_SR1, 8'h00, q);
         wrt(IDX_DRL, seed);
         wait_got();
         chk("tx_frame", got, tx_exp(seed, m));
      end
      wrt(IDX_CR1, 8'h00);
      wrt(IDX_CR2, 8'h0C);
      seed = lfsr(seed);
      u_peer.send(seed);
      for (int n = 0; n < 30 && q[5] !== 1'b1; n++) bus(1'b0, IDX_SR1, 8'h00, q);
      chk("rx_full", {7'h00, q[5]}, 8'h01);
      rdc("rx_data", IDX_DRL, seed);
      stp <= 1'b1;
      repeat (20) @(posedge clk);
      stp <= 1'b0;
      wrt(IDX_CR1, 8'h40);
      wt <= 1'b1;
      repeat (20) @(posedge clk);
      wt <= 1'b0;
      rdc("halt_keeps", IDX_CR2, 8'h0C);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      rdc("rst_cr2", IDX_CR2, 8'h00);
      close_out();
   end
endmodule : async_serial_baud_core_tb_top
